// [design/dxr_debug_exit.sv]
// Debug exit, clock return and program counter control for the core
`timescale 1ns/1ps
module dxr_debug_exit
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    input  wire logic        breakpointHit,
    input  wire logic        watchpointHit,
    input  wire logic        debugRequest,
    input  wire logic        exceptionPending,
    input  wire logic        vectorFetched,
    input  wire logic        narrowState,
    input  wire logic        fetchDone,
    input  wire logic        memAccessDone,
    input  wire logic        memAbort,
    output logic             tdo,
    output logic             debug_acknowledge,
    output logic             debugClockSelect,
    output logic             pipelineFlush,
    output logic             instrLoad,
    output logic [31:0]      pipeInstr,
    output logic             system_speed_flag,
    output logic [4:0]       debugStatus,
    output logic             abortModeEnter,
    output logic             fetchEnable,
    output logic [31:0]      programCounter
);

    // ==================================================================
    // State record
    typedef struct packed {
        logic [2:0]  tckSync;
        logic [1:0]  tmsSync;
        logic [1:0]  tdiSync;
        logic [3:0]  tapState;
        logic [3:0]  irShift;
        logic [3:0]  irCur;
        logic [32:0] drShift;
        logic [32:0] chain;
        dxr_pkg::dxr_phase_t phase;
        logic        resumeArmed;
        logic        watchHeld;
        logic [1:0]  fetchCount;
        logic        tdo;
        logic        ack;
        logic        clkSel;
        logic        flush;
        logic        load;
        logic        sysFlag;
        logic        sysDone;
        logic        abortEnter;
        logic        fetchEn;
        logic [31:0] pc;
    } dxr_state_t;

    dxr_state_t cur;
    dxr_state_t next_cur;

    logic tckRise;
    logic tckFall;
    logic tmsS;
    logic enterDebug;

    // ==================================================================
    // Sampled link pins, read only after the second flop
    assign tckRise = cur.tckSync[1] & ~cur.tckSync[2];
    assign tckFall = ~cur.tckSync[1] & cur.tckSync[2];
    assign tmsS    = cur.tmsSync[1];

    // Entry causes; watchpoint with exception holds off to vector fetch
    assign enterDebug = breakpointHit | debugRequest
                      | (watchpointHit & ~exceptionPending)
                      | (cur.watchHeld & vectorFetched);

    // ==================================================================
    // Next state logic
    always_comb
    begin
        next_cur         = cur;
        next_cur.tckSync = {cur.tckSync[1:0], tck};
        next_cur.tmsSync = {cur.tmsSync[0], tms};
        next_cur.tdiSync = {cur.tdiSync[0], tdi};
        next_cur.flush   = 1'b0;
        next_cur.load    = 1'b0;
        next_cur.abortEnter = 1'b0;

        // TAP controller advances on rising link clock
        if (tckRise)
        begin
            case (cur.tapState)
                dxr_pkg::TAP_RESET:      next_cur.tapState = tmsS ? dxr_pkg::TAP_RESET : dxr_pkg::TAP_IDLE;
                dxr_pkg::TAP_IDLE:       next_cur.tapState = tmsS ? dxr_pkg::TAP_SELECT_DR : dxr_pkg::TAP_IDLE;
                dxr_pkg::TAP_SELECT_DR:  next_cur.tapState = tmsS ? dxr_pkg::TAP_SELECT_IR : dxr_pkg::TAP_CAPTURE_DR;
                dxr_pkg::TAP_CAPTURE_DR: next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT1_DR : dxr_pkg::TAP_SHIFT_DR;
                dxr_pkg::TAP_SHIFT_DR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT1_DR : dxr_pkg::TAP_SHIFT_DR;
                dxr_pkg::TAP_EXIT1_DR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_UPDATE_DR : dxr_pkg::TAP_PAUSE_DR;
                dxr_pkg::TAP_PAUSE_DR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT2_DR : dxr_pkg::TAP_PAUSE_DR;
                dxr_pkg::TAP_EXIT2_DR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_UPDATE_DR : dxr_pkg::TAP_SHIFT_DR;
                dxr_pkg::TAP_UPDATE_DR:  next_cur.tapState = tmsS ? dxr_pkg::TAP_SELECT_DR : dxr_pkg::TAP_IDLE;
                dxr_pkg::TAP_SELECT_IR:  next_cur.tapState = tmsS ? dxr_pkg::TAP_RESET : dxr_pkg::TAP_CAPTURE_IR;
                dxr_pkg::TAP_CAPTURE_IR: next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT1_IR : dxr_pkg::TAP_SHIFT_IR;
                dxr_pkg::TAP_SHIFT_IR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT1_IR : dxr_pkg::TAP_SHIFT_IR;
                dxr_pkg::TAP_EXIT1_IR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_UPDATE_IR : dxr_pkg::TAP_PAUSE_IR;
                dxr_pkg::TAP_PAUSE_IR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_EXIT2_IR : dxr_pkg::TAP_PAUSE_IR;
                dxr_pkg::TAP_EXIT2_IR:   next_cur.tapState = tmsS ? dxr_pkg::TAP_UPDATE_IR : dxr_pkg::TAP_SHIFT_IR;
                dxr_pkg::TAP_UPDATE_IR:  next_cur.tapState = tmsS ? dxr_pkg::TAP_SELECT_DR : dxr_pkg::TAP_IDLE;
                default:                 next_cur.tapState = dxr_pkg::TAP_RESET;
            endcase
            // Shift in, MSB first so the flag lands in bit 32 last-leading
            if (cur.tapState == dxr_pkg::TAP_SHIFT_DR)
                next_cur.drShift = {cur.drShift[31:0], cur.tdiSync[1]};
            if (cur.tapState == dxr_pkg::TAP_SHIFT_IR)
                next_cur.irShift = {cur.tdiSync[1], cur.irShift[3:1]};
            if (cur.tapState == dxr_pkg::TAP_CAPTURE_IR)
                next_cur.irShift = 4'h1;
            if (cur.tapState == dxr_pkg::TAP_CAPTURE_DR)
                next_cur.drShift = cur.chain;
            if (cur.tapState == dxr_pkg::TAP_UPDATE_IR)
            begin
                next_cur.irCur = cur.irShift;
                next_cur.resumeArmed = (cur.irShift == dxr_pkg::IR_RESUME);
            end
            // Update loads scan chain 1 only; core otherwise static
            if (cur.tapState == dxr_pkg::TAP_UPDATE_DR && cur.phase == dxr_pkg::DXR_DEBUG)
                next_cur.chain = cur.drShift;
            if (cur.tapState == dxr_pkg::TAP_RESET)
                next_cur.irCur = dxr_pkg::IR_RESET_VAL;
        end

        // Data out changes on falling link clock
        if (tckFall)
            next_cur.tdo = (cur.tapState == dxr_pkg::TAP_SHIFT_DR) ? cur.drShift[32]
                                                                   : cur.irShift[0];

        // Core phase control
        case (cur.phase)
            dxr_pkg::DXR_RUN, dxr_pkg::DXR_EXITFETCH:
            begin
                if (cur.phase == dxr_pkg::DXR_EXITFETCH && fetchDone)
                begin
                    // Acknowledge masks three refetches after exit
                    next_cur.fetchCount = cur.fetchCount + 2'h1;
                    if (cur.fetchCount == dxr_pkg::MASK_FETCHES - 2'h1)
                    begin
                        next_cur.ack   = 1'b0;
                        next_cur.phase = dxr_pkg::DXR_RUN;
                    end
                end
                if (watchpointHit && exceptionPending)
                    next_cur.watchHeld = 1'b1;
                if (enterDebug)
                begin
                    next_cur.ack       = 1'b1;
                    next_cur.flush     = 1'b1;
                    next_cur.fetchEn   = 1'b0;
                    next_cur.watchHeld = 1'b0;
                    next_cur.phase     = dxr_pkg::DXR_ENTRY;
                    if (breakpointHit)
                        next_cur.pc = cur.pc + (narrowState ? dxr_pkg::ENTRY_NARROW
                                                            : dxr_pkg::ENTRY_WIDE);
                    else
                        next_cur.pc = cur.pc + (narrowState ? dxr_pkg::HALF_STEP : dxr_pkg::WORD_STEP)
                                    * {28'h0, dxr_pkg::ENTRY_ADDRS};
                end
            end
            dxr_pkg::DXR_ENTRY:
            begin
                next_cur.clkSel = 1'b1;
                next_cur.phase  = dxr_pkg::DXR_DEBUG;
            end
            dxr_pkg::DXR_DEBUG:
            begin
                // Update-DR clocks the chain instruction into the core
                if (tckRise && cur.tapState == dxr_pkg::TAP_UPDATE_DR)
                begin
                    next_cur.load    = 1'b1;
                    next_cur.sysFlag = cur.drShift[dxr_pkg::SPEED_BIT];
                    next_cur.sysDone = 1'b0;
                    next_cur.pc      = cur.pc + dxr_pkg::WORD_STEP;
                end
                // Resume only when idle is entered with resume selected,
                // including a selection made on this same link clock edge
                if (tckRise && next_cur.resumeArmed && cur.tapState != dxr_pkg::TAP_IDLE
                    && next_cur.tapState == dxr_pkg::TAP_IDLE)
                begin
                    next_cur.clkSel  = 1'b0;
                    next_cur.fetchEn = 1'b1;
                    next_cur.resumeArmed = 1'b0;
                    if (cur.sysFlag && cur.chain[dxr_pkg::INSTR_W-1:0] != 32'h0)
                        next_cur.phase = dxr_pkg::DXR_SYSACC;
                    else
                    begin
                        next_cur.phase      = dxr_pkg::DXR_EXITFETCH;
                        next_cur.fetchCount = 2'h0;
                        next_cur.sysFlag    = 1'b0;
                    end
                end
            end
            dxr_pkg::DXR_SYSACC:
            begin
                if (memAccessDone || memAbort)
                begin
                    next_cur.ack        = 1'b0;
                    next_cur.sysDone    = 1'b1;
                    next_cur.sysFlag    = 1'b1;
                    next_cur.abortEnter = memAbort;
                    next_cur.pc         = cur.pc + dxr_pkg::WORD_STEP
                                        * {28'h0, dxr_pkg::SYS_ADDRS - 4'h1};
                    next_cur.fetchEn    = 1'b0;
                    next_cur.phase      = dxr_pkg::DXR_ENTRY;
                end
            end
            default: next_cur.phase = dxr_pkg::DXR_RUN;
        endcase

        // Acknowledge rises again on return to debug
        if (cur.phase == dxr_pkg::DXR_ENTRY)
            next_cur.ack = 1'b1;
    end

    // ==================================================================
    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur         <= '0;
            cur.phase   <= dxr_pkg::DXR_RUN;
            cur.tapState <= dxr_pkg::TAP_RESET;
            cur.irCur   <= dxr_pkg::IR_RESET_VAL;
            cur.fetchEn <= 1'b1;
        end
        else
            cur <= next_cur;
    end

    // ==================================================================
    // Outputs straight from the state record
    assign tdo               = cur.tdo;
    assign debug_acknowledge = cur.ack;
    assign debugClockSelect  = cur.clkSel;
    assign pipelineFlush     = cur.flush;
    assign instrLoad         = cur.load;
    assign pipeInstr         = cur.chain[31:0];
    assign system_speed_flag = cur.sysFlag;
    assign debugStatus       = {1'b0, cur.sysDone, 3'h0};
    assign abortModeEnter    = cur.abortEnter;
    assign fetchEnable       = cur.fetchEn;
    assign programCounter    = cur.pc;

endmodule : dxr_debug_exit

// [design/dxr_pkg.sv]
// Package of constants for the debug exit and return control block
package dxr_pkg;

    // ==================================================================
    // Scan chain 1 layout
    localparam int unsigned CHAIN_LEN      = 33;
    localparam int unsigned SPEED_BIT      = 32;
    localparam int unsigned INSTR_W        = 32;

    // ==================================================================
    // TAP states (IEEE 1149.1 encoding of the controller state number)
    localparam logic [3:0] TAP_RESET       = 4'hf;
    localparam logic [3:0] TAP_IDLE        = 4'hc;
    localparam logic [3:0] TAP_SELECT_DR   = 4'h7;
    localparam logic [3:0] TAP_CAPTURE_DR  = 4'h6;
    localparam logic [3:0] TAP_SHIFT_DR    = 4'h2;
    localparam logic [3:0] TAP_EXIT1_DR    = 4'h1;
    localparam logic [3:0] TAP_PAUSE_DR    = 4'h3;
    localparam logic [3:0] TAP_EXIT2_DR    = 4'h0;
    localparam logic [3:0] TAP_UPDATE_DR   = 4'h5;
    localparam logic [3:0] TAP_SELECT_IR   = 4'h4;
    localparam logic [3:0] TAP_CAPTURE_IR  = 4'he;
    localparam logic [3:0] TAP_SHIFT_IR    = 4'ha;
    localparam logic [3:0] TAP_EXIT1_IR    = 4'h9;
    localparam logic [3:0] TAP_PAUSE_IR    = 4'hb;
    localparam logic [3:0] TAP_EXIT2_IR    = 4'h8;
    localparam logic [3:0] TAP_UPDATE_IR   = 4'hd;

    // ==================================================================
    // TAP instruction register
    localparam int unsigned IR_W           = 4;
    localparam logic [3:0]  IR_RESUME      = 4'h4;
    localparam logic [3:0]  IR_INTEST      = 4'hc;
    localparam logic [3:0]  IR_RESET_VAL   = 4'he;

    // ==================================================================
    // Program counter advance amounts in bytes; ENTRY_ADDRS and SYS_ADDRS in instruction addresses
    localparam logic [31:0] ENTRY_WIDE     = 32'h00000010;
    localparam logic [31:0] ENTRY_NARROW   = 32'h00000008;
    localparam logic [31:0] WORD_STEP      = 32'h00000004;
    localparam logic [31:0] HALF_STEP      = 32'h00000002;
    localparam logic [3:0]  ENTRY_ADDRS    = 4'h4;
    localparam logic [3:0]  SYS_ADDRS      = 4'h5;

    // ==================================================================
    // Status bit position of system access complete
    localparam int unsigned SYS_DONE_BIT   = 3;

    // Main clock fetches masked after exit
    localparam logic [1:0]  MASK_FETCHES   = 2'h3;

    // Core phases
    typedef enum logic [2:0] {
        DXR_RUN,
        DXR_ENTRY,
        DXR_DEBUG,
        DXR_SYSACC,
        DXR_EXITFETCH
    } dxr_phase_t;

endpackage : dxr_pkg

// [verification/dxr_debug_exit_monitor.sv]
// Port-level assertions for the debug exit block
`timescale 1ns/1ps
module dxr_debug_exit_monitor
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        breakpointHit,
    input wire logic        watchpointHit,
    input wire logic        debugRequest,
    input wire logic        exceptionPending,
    input wire logic        vectorFetched,
    input wire logic        memAccessDone,
    input wire logic        memAbort,
    input wire logic        debug_acknowledge,
    input wire logic        debugClockSelect,
    input wire logic        pipelineFlush,
    input wire logic        instrLoad,
    input wire logic [31:0] pipeInstr,
    input wire logic        abortModeEnter
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ==================================================================
    // Steps of a system-speed access returning to debug
    sequence sys_drop_s;
        ##[1:8] !debug_acknowledge;
    endsequence
    sequence sys_back_s;
        sys_drop_s ##[1:8] debug_acknowledge;
    endsequence

    // ==================================================================
    // Entry, clock switch and exit
    entry_ack_a: assert property ((breakpointHit || debugRequest) && !debug_acknowledge
        |=> debug_acknowledge && pipelineFlush) else $error("no ack or flush on entry");
    clock_switch_a: assert property (pipelineFlush |=> debugClockSelect)
        else $error("debug clock not taken after entry");
    flush_pulse_a: assert property (pipelineFlush |=> !pipelineFlush)
        else $error("flush longer than one cycle");
    debug_ack_a: assert property (debugClockSelect |-> debug_acknowledge)
        else $error("ack low while in debug");
    exit_hold_a: assert property ($fell(debugClockSelect) |-> debug_acknowledge [*3])
        else $error("ack dropped right after exit");
    pipe_static_a: assert property (debugClockSelect && $past(debugClockSelect)
        && $changed(pipeInstr) |-> instrLoad || $past(instrLoad))
        else $error("pipeline changed between loads");
    watch_hold_a: assert property (watchpointHit && exceptionPending && !vectorFetched
        && !debug_acknowledge |=> !debug_acknowledge) else $error("entry before vector");
    sys_ack_a: assert property (memAccessDone && debug_acknowledge && !debugClockSelect
        |-> sys_back_s) else $error("ack did not fall and rise after access");
    abort_mode_a: assert property (memAbort && debug_acknowledge && !debugClockSelect
        |-> ##[1:4] abortModeEnter) else $error("no abort mode after aborted access");
endmodule : dxr_debug_exit_monitor

bind dxr_debug_exit dxr_debug_exit_monitor u_mon (.clk_sys, .rst_n, .breakpointHit,
    .watchpointHit, .debugRequest, .exceptionPending, .vectorFetched, .memAccessDone,
    .memAbort, .debug_acknowledge, .debugClockSelect, .pipelineFlush, .instrLoad,
    .pipeInstr, .abortModeEnter);

// [verification/dxr_jtag_host.sv]
// Behavioural debugger driving the test access port
`timescale 1ns/1ps
module dxr_jtag_host
(
    output logic tck,
    output logic tms,
    output logic tdi
);
    // Link clock rests low outside frames
    initial {tck, tms, tdi} = 3'h2;

    // One link clock of 160 ns
    task automatic pulse_tck(input logic m, input logic d);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        #80 tck = 1'b0;
    endtask : pulse_tck

    // Chain entry, flag first, then word from the top bit down
    task automatic scan_dr(input logic [32:0] v);
        pulse_tck(1'b1, ~tdi);
        pulse_tck(1'b0, ~tdi);
        pulse_tck(1'b0, ~tdi);
        for (int i = 32; i >= 0; i--)
            pulse_tck(i == 0, v[i]);
        pulse_tck(1'b1, ~tdi);
        pulse_tck(1'b0, ~tdi);
    endtask : scan_dr

    // Instruction scan; may stop in update to delay the idle entry
    task automatic scan_ir(input logic [3:0] v, input logic goIdle);
        pulse_tck(1'b1, ~tdi);
        pulse_tck(1'b1, ~tdi);
        pulse_tck(1'b0, ~tdi);
        pulse_tck(1'b0, ~tdi);
        for (int i = 0; i < 4; i++)
            pulse_tck(i == 3, v[i]);
        pulse_tck(1'b1, ~tdi);
        if (goIdle)
            pulse_tck(1'b0, ~tdi);
    endtask : scan_ir

    // Return branch for n debug-speed and s system-speed steps
    function automatic logic [31:0] branch(input int n, input int s);
        logic [31:0] off;
        off = -(4 + n + 5 * s);
        return {8'hea, off[23:0]};
    endfunction : branch
endmodule : dxr_jtag_host

// [verification/testbench.sv]
// Self-checking bench for the debug exit block
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        breakpointHit, watchpointHit, debugRequest, exceptionPending;
    logic        vectorFetched, narrowState, fetchDone, memAccessDone, memAbort;
    logic        tck, tms, tdi, tdo, debug_acknowledge, debugClockSelect, pipelineFlush;
    logic        instrLoad, system_speed_flag, abortModeEnter, fetchEnable;
    logic [4:0]  debugStatus;
    logic [31:0] pipeInstr, programCounter, pc0;
    logic [34:0] tdoSeen = 35'h0;
    int          err_total = 0;
    int          n_tests = 0;

    // ==================================================================
    // Clock, partner and block
    always #2.5 clk_sys = ~clk_sys;
    dxr_jtag_host host (.tck, .tms, .tdi);
    dxr_debug_exit DUT (.clk_sys, .rst_n, .tck, .tms, .tdi, .breakpointHit, .watchpointHit,
        .debugRequest, .exceptionPending, .vectorFetched, .narrowState, .fetchDone,
        .memAccessDone, .memAbort, .tdo, .debug_acknowledge, .debugClockSelect,
        .pipelineFlush, .instrLoad, .pipeInstr, .system_speed_flag, .debugStatus,
        .abortModeEnter, .fetchEnable, .programCounter);

    // Link data seen by the debugger at each rising link clock
    always @(posedge tck)
        tdoSeen <= {tdoSeen[33:0], tdo};

    // ==================================================================
    // Shared helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Load branch and final no-op, resume, then count three fetches
    task automatic do_exit();
        host.scan_ir(dxr_pkg::IR_INTEST, 1'b1);
        pc0 = programCounter;
        host.scan_dr({1'b0, host.branch(1, 0)});
        cyc(4);
        check("branch loaded", pipeInstr, host.branch(1, 0));
        check("pc per step", programCounter, pc0 + dxr_pkg::WORD_STEP);
        host.scan_dr({1'b1, 32'h0});
        check("flag read back", tdoSeen[34], 1'b0);
        check("chain read back", tdoSeen[33:2], host.branch(1, 0));
        host.scan_ir(dxr_pkg::IR_RESUME, 1'b0);
        cyc(20);
        check("held before idle", debugClockSelect, 1'b1);
        host.pulse_tck(1'b0, 1'b1);
        cyc(8);
        check("main clock back", debugClockSelect, 1'b0);
        check("fetch on", fetchEnable, 1'b1);
        repeat (3)
        begin
            check("ack over fetches", debug_acknowledge, 1'b1);
            fetchDone = 1'b1;
            cyc(1);
            fetchDone = 1'b0;
            cyc(2);
        end
        check("ack after fetches", debug_acknowledge, 1'b0);
    endtask : do_exit

    // ==================================================================
    // Scenarios
    task automatic t_entry(input logic dreq, input logic nar);
        narrowState = nar;
        pc0 = programCounter;
        {debugRequest, breakpointHit} = {dreq, !dreq};
        cyc(1);
        {debugRequest, breakpointHit} = 2'h0;
        check("ack on entry", debug_acknowledge, 1'b1);
        check("flush on entry", pipelineFlush, 1'b1);
        check("pc on entry", programCounter,
            pc0 + (nar ? dxr_pkg::ENTRY_NARROW : dxr_pkg::ENTRY_WIDE));
        cyc(1);
        check("debug clock", debugClockSelect, 1'b1);
        narrowState = 1'b0;
        do_exit();
        $display("test entry cause %0d state %0d done", dreq, nar);
    endtask : t_entry

    task automatic t_watch();
        {watchpointHit, exceptionPending} = 2'h3;
        cyc(6);
        check("held for vector", debug_acknowledge, 1'b0);
        pc0 = programCounter;
        vectorFetched = 1'b1;
        cyc(1);
        {watchpointHit, exceptionPending, vectorFetched} = 3'h0;
        cyc(2);
        check("ack after vector", debug_acknowledge, 1'b1);
        check("pc on watch", programCounter, pc0 + dxr_pkg::ENTRY_WIDE);
        do_exit();
        $display("test watchpoint with exception done");
    endtask : t_watch

    task automatic t_sys(input logic ab);
        logic fell;
        logic hit;
        {fell, hit} = 2'h0;
        debugRequest = 1'b1;
        cyc(1);
        debugRequest = 1'b0;
        host.scan_ir(dxr_pkg::IR_INTEST, 1'b1);
        pc0 = programCounter;
        host.scan_dr({1'b1, 32'he5901000});
        cyc(4);
        host.scan_ir(dxr_pkg::IR_RESUME, 1'b1);
        cyc(8);
        check("ack in access", debug_acknowledge, 1'b1);
        check("main clock in access", debugClockSelect, 1'b0);
        {memAccessDone, memAbort} = {!ab, ab};
        cyc(1);
        {memAccessDone, memAbort} = 2'h0;
        repeat (20)
        begin
            fell |= !debug_acknowledge;
            hit |= abortModeEnter;
            cyc(1);
        end
        check("abort mode", hit, ab);
        check("ack back", debug_acknowledge, 1'b1);
        if (!ab)
        begin
            check("ack fell", fell, 1'b1);
            check("access done", debugStatus[dxr_pkg::SYS_DONE_BIT], 1'b1);
            check("flag kept", system_speed_flag, 1'b1);
            check("pc on access", programCounter,
                pc0 + {28'h0, dxr_pkg::SYS_ADDRS} * dxr_pkg::WORD_STEP);
        end
        do_exit();
        $display("test system access abort %0d done", ab);
    endtask : t_sys

    // ==================================================================
    // Main sequence
    initial
    begin
        {breakpointHit, watchpointHit, debugRequest, exceptionPending} = 4'h0;
        {vectorFetched, narrowState, fetchDone, memAccessDone, memAbort} = 5'h0;
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        cyc(2);
        check("reset ack", debug_acknowledge, 1'b0);
        check("reset fetch", fetchEnable, 1'b1);
        host.pulse_tck(1'b0, 1'b0);
        cyc(4);
        t_entry(1'b0, 1'b0);
        t_entry(1'b0, 1'b1);
        t_entry(1'b1, 1'b0);
        t_watch();
        t_sys(1'b0);
        t_sys(1'b1);
        give_verdict();
    end

    // Watchdog well beyond the expected run of about 113 us
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule : testbench
